/* File: verilog/rcs_map.vh */
// Purpose: constants of the reset and clock sequencer
// Assumes: AXI4-Lite byte addresses, one register per word
// Notes:   counts are in reference clock cycles
`ifndef RCS_MAP_VH
`define RCS_MAP_VH
// Register byte offsets
`define RCS_OFF_CAUSE   4'h0
`define RCS_OFF_CTRL    4'h4
`define RCS_OFF_STAT    4'h8
`define RCS_OFF_SVC     4'hC
// Reset cause bit positions
`define RCS_C_POR       0
`define RCS_C_PIN       1
`define RCS_C_WDOG      2
`define RCS_C_BADOP     3
`define RCS_C_BADAD     4
`define RCS_C_LOWV      5
// Control bit positions
`define RCS_K_STOP      0
`define RCS_K_WAIT      1
`define RCS_K_SHORT     2
`define RCS_K_MON       3
`define RCS_K_PLL       4
// Reset values
`define RCS_CTRL_RST    5'h00
`define RCS_CAUSE_RST   6'h01
// Timing counts
`define RCS_POR_CYC     13'h1000
`define RCS_DRV_CYC     6'h20
`define RCS_HOLD_CYC    6'h20
`define RCS_SREC_LONG   13'h1000
`define RCS_SREC_SHORT  13'h0020
`define RCS_PIN_STD     13'h0043
`define RCS_PIN_POR     13'h1043
`define RCS_BUS_DIV     3'h4
// Reset vectors
`define RCS_VEC_USER    16'hFFFE
`define RCS_VEC_MON     16'hFEFE
// Bus responses
`define RCS_RESP_OK     2'h0
`define RCS_RESP_ERR    2'h2
`endif

/* File: verilog/rcs_top.v */
// Purpose: reset sequencing, bus clock gating and watchdog
// Assumes: clock is the oscillator reference clock
// Notes:   AXI4-Lite register slave, reset pin is open drain
//
// Overview of operation
// - Bus runs at selected clock divided four
// - Power-on holds clocks off, pin low 4096 plus 32
// - Stop exit waits 4096 or 32 cycles
// - Wait stops CPU clock, peripherals keep clocks
// - Every source resets and selects reset vector
// - Internal reset returns registers to defaults
// - Internal reset clears counter, pin reset not
// - Each source sets its own cause flag
// - Pin low halts; flag after 67 cycles
// - Pin flag needs 4163 after power-on
// - Internal source drives pin 32, holds 32
// - Power-on counts 4096 then internal sequence
// - Watchdog request taken asynchronously
// - Release from reset 64 after 4096
// - Power-on asserts reset, enables clock generator
// - Power-on sets its flag, clears others
// - Watchdog overflow resets and sets flag
// - Service write clears watchdog, counter 12:4
// - Counter overflow ticks the watchdog
// - Monitor mode test voltage disables watchdog
// - Break with reset-pin test voltage disables watchdog
// - System counter thirteen bits wide
// - Bad opcode sets flag and resets
// - Bad opcode fetch address resets, data not
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "rcs_map.vh"

module rcs_top #(
  parameter [12:0] POR_CYC   = `RCS_POR_CYC,
  parameter [12:0] SREC_LONG = `RCS_SREC_LONG,
  parameter [12:0] SREC_SHRT = `RCS_SREC_SHORT,
  parameter [12:0] PIN_STD   = `RCS_PIN_STD,
  parameter [12:0] PIN_POR   = `RCS_PIN_POR,
  parameter        WD_W      = 6
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        power_on_pulse,
  input  wire        low_voltage_in,
  input  wire        bad_opcode_in,
  input  wire        bad_fetch_address_in,
  input  wire        opcode_fetch_in,
  input  wire        watchdog_async_req,
  input  wire        test_high_voltage_rst,
  input  wire        test_high_voltage_irq,
  input  wire        break_state,
  input  wire        wake_event,
  input  wire        pll_out_tick,
  input  wire        reset_pin_in,
  output reg         reset_pin_out,
  output reg         reset_pin_oe_n,
  output reg         internal_reset,
  output reg         cpu_clk_en,
  output reg         periph_clk_en,
  output reg         bus_tick,
  output reg         clock_gen_output_en,
  output reg  [15:0] reset_vector,
  output reg         watchdog_off
);

  // Sequencer states
  localparam [2:0] S_RUN  = 3'h0;
  localparam [2:0] S_PORW = 3'h1;
  localparam [2:0] S_DRV  = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_EXT  = 3'h4;
  localparam [2:0] S_STOP = 3'h5;
  localparam [2:0] S_SREC = 3'h6;
  localparam [2:0] S_WAIT = 3'h7;
  localparam [5:0] DRV_LAST  = `RCS_DRV_CYC - 6'h01;
  localparam [5:0] HOLD_LAST = `RCS_HOLD_CYC - 6'h01;
  localparam [2:0] DIV_FULL  = `RCS_BUS_DIV - 3'h1;
  localparam [1:0] DIV_LAST  = DIV_FULL[1:0];

  reg  [2:0]      state;
  reg  [2:0]      next_state;
  reg  [12:0]     sctr;
  reg  [5:0]      seq;
  reg  [5:0]      cause;
  reg  [4:0]      ctrl;
  reg  [12:0]     pin_low;
  reg             por_seq;
  reg  [WD_W-1:0] wdog;
  reg             pin_s1;
  reg             pin_s2;
  reg             wreq_s1;
  reg             wreq_s2;
  reg             own_d1;
  reg             own_d2;
  reg  [1:0]      div;
  reg  [3:0]      aw_addr;
  reg  [31:0]     w_data;
  reg  [31:0]     next_rdata;
  reg  [1:0]      next_rresp;

  wire wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_map  = (aw_addr == `RCS_OFF_CAUSE) | (aw_addr == `RCS_OFF_CTRL)
               | (aw_addr == `RCS_OFF_STAT)  | (aw_addr == `RCS_OFF_SVC);
  wire service = wr_go & (aw_addr == `RCS_OFF_SVC);
  wire w_cause = wr_go & (aw_addr == `RCS_OFF_CAUSE);
  wire w_ctrl  = wr_go & (aw_addr == `RCS_OFF_CTRL);

  // Reset sources
  wire in_drive = (state == S_PORW) | (state == S_DRV);
  wire sys_ovf  = (sctr == 13'h1FFF);
  wire wd_ovf   = sys_ovf & ~watchdog_off & (&wdog);
  wire lowv_ev  = low_voltage_in;
  wire wdog_ev  = wd_ovf | wreq_s2;
  wire badop_ev = bad_opcode_in & (state == S_RUN);
  wire badad_ev = bad_fetch_address_in & opcode_fetch_in
                & (state == S_RUN);
  wire int_ev   = wdog_ev | badop_ev | badad_ev;
  wire int_go   = int_ev & ~in_drive;
  // Echo of our own drive is masked until the synchronised pin catches up
  wire pin_go   = ~pin_s2 & own_d2 & ~in_drive & (state != S_EXT) & ~int_ev;
  wire [12:0] pin_thr   = por_seq ? PIN_POR : PIN_STD;
  wire [12:0] srec_last = ctrl[`RCS_K_SHORT] ? SREC_SHRT - 13'h0001
                                             : SREC_LONG - 13'h0001;
  wire [12:0] por_last  = POR_CYC - 13'h0001;

  // Watchdog disable from test voltage only
  wire wd_dis = (ctrl[`RCS_K_MON]
                 & (test_high_voltage_rst | test_high_voltage_irq))
              | (break_state & test_high_voltage_rst);

  // Next sequencer state
  always @*
  begin
    next_state = state;
    if (power_on_pulse | lowv_ev)
      next_state = S_PORW;
    else if (int_go)
      next_state = S_DRV;
    else if (pin_go)
      next_state = S_EXT;
    else
    begin
      case (state)
        S_PORW:
          if (sctr == por_last)
            next_state = S_DRV;
        S_DRV:
          if (seq == DRV_LAST)
            next_state = S_HOLD;
        S_HOLD:
          if (seq == HOLD_LAST)
            next_state = S_RUN;
        S_EXT:
          if (pin_s2)
            next_state = S_HOLD;
        S_RUN:
          if (ctrl[`RCS_K_STOP])
            next_state = S_STOP;
          else if (ctrl[`RCS_K_WAIT])
            next_state = S_WAIT;
        S_STOP:
          if (wake_event)
            next_state = S_SREC;
        S_SREC:
          if (sctr == srec_last)
            next_state = S_RUN;
        S_WAIT:
          if (wake_event)
            next_state = S_RUN;
        default:
          next_state = S_PORW;
      endcase
    end
  end

  // Synchronisers for pin and watchdog request
  always @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1  <= 1'b1;
      pin_s2  <= 1'b1;
      wreq_s1 <= 1'b0;
      wreq_s2 <= 1'b0;
      own_d1  <= 1'b0;
      own_d2  <= 1'b0;
    end
    else
    begin
      pin_s1  <= reset_pin_in;
      pin_s2  <= pin_s1;
      wreq_s1 <= watchdog_async_req;
      wreq_s2 <= wreq_s1;
      // Pin enable delayed to line up with the pin synchroniser
      own_d1  <= reset_pin_oe_n;
      own_d2  <= own_d1;
    end
  end

  // State, sequence count and system counter
  always @(posedge clock)
  begin
    if (rst)
    begin
      state   <= S_PORW;
      seq     <= 6'h00;
      sctr    <= 13'h0000;
      por_seq <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        seq <= 6'h00;
      else
        seq <= seq + 6'h01;
      if (power_on_pulse | lowv_ev | int_go)
        sctr <= 13'h0000;
      else if ((next_state == S_STOP) && (state != S_STOP))
        sctr <= 13'h0000;
      else if ((next_state == S_SREC) && (state != S_SREC))
        sctr <= 13'h0000;
      else if (service)
        sctr <= sctr & 13'h000F;
      else
        sctr <= sctr + 13'h0001;
      if (power_on_pulse | lowv_ev)
        por_seq <= 1'b1;
      else if (next_state == S_RUN)
        por_seq <= 1'b0;
    end
  end

  // Watchdog counter
  always @(posedge clock)
  begin
    if (rst)
      wdog <= {WD_W{1'b0}};
    else if (service | internal_reset)
      wdog <= {WD_W{1'b0}};
    else if (sys_ovf & ~watchdog_off)
      wdog <= wdog + {{(WD_W-1){1'b0}}, 1'b1};
  end

  // Pin low time and cause flags
  always @(posedge clock)
  begin
    if (rst)
    begin
      pin_low <= 13'h0000;
      cause   <= `RCS_CAUSE_RST;
    end
    else
    begin
      if (pin_s2)
        pin_low <= 13'h0000;
      else if (pin_low != 13'h1FFF)
        pin_low <= pin_low + 13'h0001;
      if (power_on_pulse)
        cause <= 6'h01 << `RCS_C_POR;
      else
      begin
        cause <= (cause & ~(w_cause ? w_data[5:0] : 6'h00))
               | ({5'h00, lowv_ev} << `RCS_C_LOWV)
               | ({5'h00, wdog_ev} << `RCS_C_WDOG)
               | ({5'h00, badop_ev} << `RCS_C_BADOP)
               | ({5'h00, badad_ev} << `RCS_C_BADAD)
               | ({5'h00, ~pin_s2 & (pin_low == pin_thr - 13'h0001)
                   & ~lowv_ev} << `RCS_C_PIN);
      end
    end
  end

  // Control register, defaults while in reset
  always @(posedge clock)
  begin
    if (rst | internal_reset)
      ctrl <= `RCS_CTRL_RST;
    else if (w_ctrl)
      ctrl <= w_data[4:0];
    else
    begin
      if (next_state == S_STOP)
        ctrl[`RCS_K_STOP] <= 1'b0;
      if (next_state == S_WAIT)
        ctrl[`RCS_K_WAIT] <= 1'b0;
    end
  end

  // Clock gating, reset pin and vector outputs
  always @(posedge clock)
  begin
    if (rst)
    begin
      internal_reset      <= 1'b1;
      reset_pin_out       <= 1'b0;
      reset_pin_oe_n      <= 1'b0;
      cpu_clk_en          <= 1'b0;
      periph_clk_en       <= 1'b0;
      clock_gen_output_en <= 1'b1;
      reset_vector        <= `RCS_VEC_USER;
      watchdog_off        <= 1'b0;
      bus_tick            <= 1'b0;
      div                 <= 2'h0;
    end
    else
    begin
      internal_reset <= (next_state == S_PORW) | (next_state == S_DRV)
                      | (next_state == S_HOLD)
                      | (next_state == S_EXT);
      reset_pin_oe_n <= ~((next_state == S_PORW)
                      | (next_state == S_DRV));
      cpu_clk_en     <= (next_state == S_RUN);
      periph_clk_en  <= (next_state == S_RUN)
                      | (next_state == S_WAIT);
      clock_gen_output_en <= (next_state != S_STOP);
      reset_vector   <= ctrl[`RCS_K_MON] ? `RCS_VEC_MON
                                         : `RCS_VEC_USER;
      watchdog_off   <= wd_dis;
      // Divide selected clock by four
      if (~ctrl[`RCS_K_PLL] | pll_out_tick)
        div <= (div == DIV_LAST) ? 2'h0 : div + 2'h1;
      bus_tick <= (~ctrl[`RCS_K_PLL] | pll_out_tick)
                & (div == DIV_LAST) & periph_clk_en;
    end
  end

  // Write channels, taken in either order
  always @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RCS_RESP_OK;
      aw_addr       <= 4'h0;
      w_data        <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr       <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `RCS_RESP_OK : `RCS_RESP_ERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read data select
  always @*
  begin
    next_rresp = `RCS_RESP_OK;
    case ({s_axi_araddr[3:2], 2'b00})
      `RCS_OFF_CAUSE: next_rdata = {26'h0000000, cause};
      `RCS_OFF_CTRL:  next_rdata = {27'h0000000, ctrl};
      // Watchdog count stays internal, the zero fields beside the flags are left unused
      `RCS_OFF_STAT:  next_rdata = {3'h0, sctr, 5'h00, watchdog_off,
                                    internal_reset, por_seq, 5'h00, state};
      `RCS_OFF_SVC:   next_rdata = 32'h00000000;
      default:
      begin
        next_rdata = 32'h00000000;
        next_rresp = `RCS_RESP_ERR;
      end
    endcase
  end

  // Read channel
  always @(posedge clock)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RCS_RESP_OK;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // rcs_top

/* File: sim/rcs_checker_assertions.sv */
// Purpose: port checks of the reset sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every rcs_top
`timescale 1ns/100ps
module rcs_checker (
  input wire        clock,
  input wire        rst,
  input wire        test_high_voltage_rst,
  input wire        test_high_voltage_irq,
  input wire        reset_pin_oe_n,
  input wire        reset_pin_out,
  input wire        internal_reset,
  input wire        cpu_clk_en,
  input wire        periph_clk_en,
  input wire        bus_tick,
  input wire        clock_gen_output_en,
  input wire [15:0] reset_vector,
  input wire        watchdog_off
);
  wire thv;
  // Any test voltage present
  assign thv = test_high_voltage_rst | test_high_voltage_irq;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Pin pulled only as open drain and only in reset
  a_drive_in_rst: assert property (!reset_pin_oe_n |-> internal_reset && !reset_pin_out)
    else $error("pin driven outside reset");
  // Clocks stay off while reset stands
  a_clocks_held: assert property (internal_reset |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks running in reset");
  a_gen_in_rst: assert property (internal_reset |-> clock_gen_output_en)
    else $error("clock generator off in reset");
  // Bus ticks at least four clock cycles apart
  a_tick_space: assert property (bus_tick |=> !bus_tick [*3])
    else $error("bus ticks too close");
  a_tick_gated: assert property (bus_tick |-> periph_clk_en || $past(periph_clk_en))
    else $error("bus tick with clocks off");
  a_cpu_periph: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clock without peripheral clock");
  a_vector_ok: assert property (reset_vector == 16'hFFFE || reset_vector == 16'hFEFE)
    else $error("bad reset vector");
  // Internal reset outlasts the pin drive
  a_hold_after: assert property ($rose(reset_pin_oe_n) |-> internal_reset [*8])
    else $error("internal reset ended with pin");
  a_run_after: assert property ($fell(internal_reset) |-> ##[0:2] cpu_clk_en)
    else $error("cpu clock late after reset");
  a_wdog_off: assert property (watchdog_off |-> $past(thv) || $past(thv, 2))
    else $error("watchdog off without test voltage");
  c_rst_done: cover property ($fell(internal_reset));
  c_pin_rel: cover property ($rose(reset_pin_oe_n));
  c_wdog_off: cover property (watchdog_off);
endmodule // rcs_checker
bind rcs_top rcs_checker rcs_checker_inst (.clock, .rst, .test_high_voltage_rst,
  .test_high_voltage_irq, .reset_pin_oe_n, .reset_pin_out, .internal_reset, .cpu_clk_en,
  .periph_clk_en, .bus_tick, .clock_gen_output_en, .reset_vector, .watchdog_off);

/* File: sim/rcs_far.sv */
// Purpose: far side of the reset sequencer
// Assumes: reset wire has a pull-up
// Notes:   PLL edges arrive at random
`timescale 1ns/100ps
module rcs_far (
  input  wire  clock,
  input  wire  reset_pin_oe_n,
  input  wire  pull_low,
  output wire  reset_pin_in,
  output logic pll_out_tick
);
  integer seed = 32'h2b9c6191;
  // Wire low while either party pulls it
  assign reset_pin_in = reset_pin_oe_n && !pull_low;
  // Random subset of cycles carry a PLL edge
  always @(posedge clock) pll_out_tick <= $random(seed) & 1;
  initial pll_out_tick = 1'b0;
endmodule // rcs_far

/* File: sim/rcs_top_tb.sv */
// Purpose: self-checking bench of the reset sequencer
// Assumes: short power-on and stop counts
// Notes:   pin level resolved in the far-side model
`timescale 1ns/100ps
module rcs_top_tb;
  localparam int POR = 16;
  logic        clock, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, power_on_pulse, low_voltage_in, bad_opcode_in, opcode_fetch_in;
  logic        bad_fetch_address_in, watchdog_async_req, test_high_voltage_rst, wake_event;
  logic        test_high_voltage_irq, break_state, pull_low;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, v;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         reset_pin_in, reset_pin_out, reset_pin_oe_n, internal_reset, cpu_clk_en;
  wire         periph_clk_en, bus_tick, clock_gen_output_en, watchdog_off, pll_out_tick;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  reset_vector;
  integer      seed = 32'h2b9c6191;
  int          n_errors = 0, n_compared = 0, nd, nr, k, n, gap = -1, c0, e;
  bit          tick_on, pllsel;
  int          bitq[$] = '{2, 3, 4, 0, 1, 0};
  logic [24:0] tbl = 25'b10101_10011_01101_00110_01010;

  rcs_top #(.POR_CYC(13'd16), .SREC_LONG(13'd16)) rcs_top_inst (.*);
  rcs_far rcs_far_inst (.*);

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 0, s_axi_bresp);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk("rresp", 0, s_axi_rresp);
    s_axi_rready <= 0;
  endtask

  initial
  begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // Cycles with pin driven and internal reset up
  always @(posedge clock)
  begin
    nd += (reset_pin_oe_n === 1'b0);
    nr += (internal_reset === 1'b1);
  end
  // Selected edges between bus ticks
  always @(posedge clock)
    if (!tick_on || periph_clk_en !== 1'b1)
      gap = -1;
    else
    begin
      if (bus_tick === 1'b1)
      begin
        if (gap >= 0) chk("tick gap", 4, gap);
        gap = 0;
      end
      if (gap >= 0) gap += pllsel ? pll_out_tick : 1;
    end

  initial
  begin
    {rst, s_axi_wstrb} = 5'h1F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, power_on_pulse,
     low_voltage_in, bad_opcode_in, opcode_fetch_in, bad_fetch_address_in, watchdog_async_req,
     test_high_voltage_rst, wake_event, test_high_voltage_irq, break_state, pull_low,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (16) @(posedge clock);
    rst <= 0;
    @(negedge clock);
    nd = 0;
    nr = 0;
    repeat (300) @(posedge clock);
    chk("por drive", POR + 32, nd);
    chk("por hold", POR + 64, nr);
    rd(0);
    chk("cause", 1, v);
    rd(4);
    chk("control", 0, v);
    repeat (1500) @(posedge clock);
    // Internal sources, data fetch, long and short pin pulls
    for (k = 0; k < 6; k++)
    begin
      repeat (100) @(posedge clock);
      wr(0, 32'h3F);
      rd(8);
      c0 = v[28:16];
      n = k == 4 ? 70 + ($random(seed) & 7) : 10 + ($random(seed) & 31);
      @(negedge clock);
      nd = 0;
      nr = 0;
      @(posedge clock);
      case (k)
        0: watchdog_async_req <= 1;
        1: bad_opcode_in <= 1;
        2: {bad_fetch_address_in, opcode_fetch_in} <= 2'b11;
        3: bad_fetch_address_in <= 1;
        default: pull_low <= 1;
      endcase
      if (k > 3) repeat (n) @(posedge clock);
      @(posedge clock);
      {watchdog_async_req, bad_opcode_in, bad_fetch_address_in, opcode_fetch_in, pull_low} <= '0;
      repeat (300) @(posedge clock);
      chk("pin drive", k < 3 ? 32 : 0, nd);
      if (k < 4) chk("reset hold", k < 3 ? 64 : 0, nr);
      rd(8);
      if (k != 3) chk("counter kept", k > 3, v[28:16] > c0);
      rd(0);
      chk("cause", k == 3 || k == 5 ? 0 : 1 << bitq[k], v);
    end
    wr(0, 32'h3F);
    @(posedge clock) low_voltage_in <= 1;
    repeat (5) @(posedge clock);
    low_voltage_in <= 0;
    repeat (300) @(posedge clock);
    rd(0);
    chk("cause", 32'h20, v);
    @(posedge clock) power_on_pulse <= 1;
    @(posedge clock) power_on_pulse <= 0;
    repeat (300) @(posedge clock);
    rd(0);
    chk("cause", 1, v);
    // Monitor, break and test voltage combinations
    for (k = 0; k < 5; k++)
    begin
      e = tbl[20 - 5 * k +: 5];
      wr(4, e[4] << 3);
      @(posedge clock) {break_state, test_high_voltage_rst, test_high_voltage_irq} <= e[3:1];
      repeat (4) @(posedge clock);
      chk("vector", e[4] ? 16'hFEFE : 16'hFFFE, reset_vector);
      chk("watchdog off", e[0], watchdog_off);
    end
    {break_state, test_high_voltage_rst, test_high_voltage_irq} <= '0;
    // Short stop, long stop, wait
    for (k = 0; k < 3; k++)
    begin
      wr(4, k == 0 ? 5 : k);
      repeat (4) @(posedge clock);
      chk("cpu clock", 0, cpu_clk_en);
      chk("periph clock", k == 2, periph_clk_en);
      chk("clock gen", k == 2, clock_gen_output_en);
      @(posedge clock) wake_event <= 1;
      @(posedge clock) wake_event <= 0;
      for (n = 0; n < 5000 && cpu_clk_en !== 1'b1; n++) @(posedge clock);
      if (k < 2) chk("stop recovery", 1, n >= 30 - 16 * k && n <= 36 - 16 * k);
    end
    // Reference then PLL clock selected
    for (k = 0; k < 2; k++)
    begin
      wr(4, k << 4);
      @(negedge clock);
      pllsel = k;
      tick_on = 1;
      repeat (400) @(posedge clock);
      @(negedge clock) tick_on = 0;
    end
    repeat (200) @(posedge clock);
    rd(8);
    c0 = v[28:16];
    // Service lands four edges after that read, the next read two edges later
    wr(12, $random(seed));
    rd(8);
    chk("counter 12:4", ((c0 + 4) & 15) + 2, v[28:16]);
    results;
  end

  // Cut a hang short
  initial
  begin
    #200000;
    n_errors++;
    results;
  end
endmodule // rcs_top_tb
